/* core/apc_config_regs.sv */
// two-wire loaded audio path configuration registers
`timescale 1ns/10ps
module apc_config_regs
  import apc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // two-wire serial pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // whole register words
  output logic [15:0]      path_config_a,
  output logic [15:0]      path_config_b,
  // config a fields
  output logic             volume_powerdown,
  output logic [1:0]       speaker_aux_ctl,
  output logic [1:0]       out_mux_sel,
  output logic             line_out_powerdown,
  output logic [2:0]       line_out_mux_sel,
  output logic             input_source_sel,
  output logic             aux_in_powerdown,
  output logic [1:0]       aux_in_gain,
  output logic             line_in_powerdown,
  output logic [1:0]       line_in_gain,
  // config b fields
  output logic             agc_amp_powerdown,
  output logic             filter_powerdown,
  output logic [1:0]       filter_rate,
  output logic             filter_mux_sel,
  output logic [1:0]       second_mixer_ctl,
  output logic [1:0]       first_mixer_ctl,
  output logic [1:0]       first_mixer_src,
  output logic [2:0]       attenuation_step,
  output logic [1:0]       level_mux_sel
);

  typedef struct packed {
    logic        scl_d;
    logic        sda_d;
    apc_state_e  state;
    apc_state_e  after;
    logic [7:0]  shift;
    logic [2:0]  bit_cnt;
    logic [1:0]  data_idx;
    apc_sel_e    sel;
    logic [7:0]  hi_byte;
    logic [7:0]  lo_byte;
    logic        ack_ok;
    logic        pend;
    logic        oe;
    logic [15:0] cfg_a;
    logic [15:0] cfg_b;
  } apc_regs_s;

  apc_regs_s q_reg;
  apc_regs_s q_next;

  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic [7:0] new_byte;
  logic       commit_a;
  logic       commit_b;

  // pins are asynchronous to mclk
  apc_sync #(
    .WIDTH (2)
  ) u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in ({scl_in, sda_in}),
    .sync_out ({scl_s, sda_s})
  );

  // map a command byte to the register it loads
  function automatic apc_sel_e decode_cmd(input logic [7:0] cmd);
    if (cmd == CMD_LOAD_A) begin
      decode_cmd = SEL_A;
    end else if (cmd == CMD_LOAD_B) begin
      decode_cmd = SEL_B;
    end else begin
      decode_cmd = SEL_NONE;
    end
  endfunction

  // bus events seen on the synchronised pins
  assign scl_rise   = scl_s & ~q_reg.scl_d;
  assign scl_fall   = ~scl_s & q_reg.scl_d;
  assign start_cond = scl_s & q_reg.scl_d & q_reg.sda_d & ~sda_s;
  assign stop_cond  = scl_s & q_reg.scl_d & ~q_reg.sda_d & sda_s;
  assign new_byte   = {q_reg.shift[6:0], sda_s};

  // a pending load is applied on the ack clock's rising edge
  assign commit_a = (q_reg.state == ST_ACK) && scl_rise && q_reg.pend
                    && (q_reg.sel == SEL_A);
  assign commit_b = (q_reg.state == ST_ACK) && scl_rise && q_reg.pend
                    && (q_reg.sel == SEL_B);

  // receiver, acknowledge and register update
  always_comb begin
    q_next       = q_reg;
    q_next.scl_d = scl_s;
    q_next.sda_d = sda_s;
    if (start_cond) begin
      // repeated start also lands here and drops any half-loaded value
      q_next.state   = ST_ADDR;
      q_next.bit_cnt = 3'h0;
      q_next.pend    = 1'b0;
      q_next.oe      = 1'b0;
    end else if (stop_cond) begin
      q_next.state = ST_IDLE;
      q_next.pend  = 1'b0;
      q_next.oe    = 1'b0;
    end else begin
      case (q_reg.state)
        ST_IDLE: begin
          q_next.oe = 1'b0;
        end
        ST_ADDR, ST_CMD, ST_DATA: begin
          if (scl_rise) begin
            q_next.shift   = new_byte;
            q_next.bit_cnt = q_reg.bit_cnt + 3'h1;
            if (q_reg.bit_cnt == BIT_LAST) begin
              q_next.state  = ST_ACK_WAIT;
              q_next.ack_ok = 1'b1;
              if (q_reg.state == ST_ADDR) begin
                // only a write to our address is answered
                q_next.ack_ok = (new_byte == {SLAVE_ADDR, 1'b0});
                q_next.after  = ST_CMD;
              end else if (q_reg.state == ST_CMD) begin
                q_next.sel      = decode_cmd(new_byte);
                q_next.data_idx = 2'h0;
                q_next.after    = ST_DATA;
              end else begin
                q_next.after = ST_DATA;
                if (q_reg.data_idx == 2'h0) begin
                  q_next.hi_byte  = new_byte;
                  q_next.data_idx = 2'h1;
                end else if (q_reg.data_idx == 2'h1) begin
                  q_next.lo_byte  = new_byte;
                  q_next.data_idx = DATA_BYTES;
                  q_next.pend     = (q_reg.sel != SEL_NONE);
                end else if (q_reg.sel != SEL_NONE) begin
                  // a third byte to a config register is refused
                  q_next.ack_ok = 1'b0;
                end
              end
            end
          end
        end
        ST_ACK_WAIT: begin
          if (scl_fall) begin
            q_next.oe    = q_reg.ack_ok;
            q_next.state = q_reg.ack_ok ? ST_ACK : ST_IGNORE;
          end
        end
        ST_ACK: begin
          if (commit_a) begin
            q_next.cfg_a = {q_reg.hi_byte, q_reg.lo_byte};
            q_next.pend  = 1'b0;
          end
          if (commit_b) begin
            q_next.cfg_b = {q_reg.hi_byte, q_reg.lo_byte};
            q_next.pend  = 1'b0;
          end
          if (scl_fall) begin
            q_next.oe      = 1'b0;
            q_next.state   = q_reg.after;
            q_next.bit_cnt = 3'h0;
          end
        end
        ST_IGNORE: begin
          q_next.oe = 1'b0;  // wait for the next start or stop
        end
        default: begin
          q_next.state = ST_IDLE;
          q_next.oe    = 1'b0;
        end
      endcase
    end
  end

  // single state register; values hold until rewritten
  always_ff @(posedge mclk) begin
    if (rst) begin
      q_reg          <= '0;
      q_reg.scl_d    <= 1'b1;
      q_reg.sda_d    <= 1'b1;
      q_reg.state    <= ST_IDLE;
      q_reg.after    <= ST_IDLE;
      q_reg.sel      <= SEL_NONE;
      q_reg.cfg_a    <= CFG_A_RESET;
      q_reg.cfg_b    <= CFG_B_RESET;
    end else begin
      q_reg <= q_next;
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = q_reg.oe;

  // whole words drive the analog controls continuously
  assign path_config_a = q_reg.cfg_a;
  assign path_config_b = q_reg.cfg_b;

  // config a fields
  assign volume_powerdown   = q_reg.cfg_a[A_VOL_PD_POS];
  assign speaker_aux_ctl    = q_reg.cfg_a[A_SPK_AUX_LSB +: 2];
  assign out_mux_sel        = q_reg.cfg_a[A_OUT_MUX_LSB +: 2];
  assign line_out_powerdown = q_reg.cfg_a[A_LINE_OUT_PD_POS];
  assign line_out_mux_sel   = q_reg.cfg_a[A_LINE_OUT_LSB +: 3];
  assign input_source_sel   = q_reg.cfg_a[A_IN_SRC_POS];
  assign aux_in_powerdown   = q_reg.cfg_a[A_AUX_PD_POS];
  assign aux_in_gain        = q_reg.cfg_a[A_AUX_GAIN_LSB +: 2];
  assign line_in_powerdown  = q_reg.cfg_a[A_LINE_IN_PD_POS];
  assign line_in_gain       = q_reg.cfg_a[A_LINE_IN_GAIN_LSB +: 2];

  // config b fields
  assign agc_amp_powerdown  = q_reg.cfg_b[B_AGC_PD_POS];
  assign filter_powerdown   = q_reg.cfg_b[B_FILT_PD_POS];
  assign filter_rate        = q_reg.cfg_b[B_FILT_RATE_LSB +: 2];
  assign filter_mux_sel     = q_reg.cfg_b[B_FILT_MUX_POS];
  assign second_mixer_ctl   = q_reg.cfg_b[B_MIX2_LSB +: 2];
  assign first_mixer_ctl    = q_reg.cfg_b[B_MIX1_LSB +: 2];
  assign first_mixer_src    = q_reg.cfg_b[B_MIX1_SRC_LSB +: 2];
  assign attenuation_step   = q_reg.cfg_b[B_ATTEN_LSB +: 3];
  assign level_mux_sel      = q_reg.cfg_b[B_LEVEL_MUX_LSB +: 2];

  // checks on the receiver and the register words
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_cfg_a_hold: assert property ($changed(path_config_a) |-> $past(commit_a))
    else $error("config a changed without a load");
  a_cfg_b_hold: assert property ($changed(path_config_b) |-> $past(commit_b))
    else $error("config b changed without a load");
  // watches the words themselves, so a commit term that drops scl_rise is still caught
  a_apply_on_rise: assert property (($changed(path_config_a) || $changed(path_config_b))
                                    |-> $past(scl_rise))
    else $error("config applied off a serial clock rising edge");
  a_pend_cleared: assert property ((commit_a || commit_b) |=> !q_reg.pend)
    else $error("pending load not cleared after it was applied");
  a_b_keeps_a: assert property (commit_b |=> $stable(path_config_a))
    else $error("loading config b disturbed config a");
  a_msb_first: assert property (commit_a |=> path_config_a[15:8] == $past(q_reg.hi_byte))
    else $error("first data byte did not land in the high half");
  a_ack_window: assert property (sda_oe |-> (q_reg.state == ST_ACK))
    else $error("data line driven outside an acknowledge");
  a_ack_release: assert property ((q_reg.state == ST_ACK) && scl_fall |=> !sda_oe)
    else $error("acknowledge not released on the clock fall");
  a_nack_refuse: assert property ((q_reg.state == ST_ACK_WAIT) && !q_reg.ack_ok && scl_fall
                                  |=> (q_reg.state == ST_IGNORE) && !sda_oe)
    else $error("refused byte was acknowledged");
  a_stop_abort: assert property (stop_cond |=> (q_reg.state == ST_IDLE) && !q_reg.pend)
    else $error("stop did not return the receiver to idle");
  // a foreign address or a read must never be answered
  a_addr_refused: assert property ((q_reg.state == ST_ADDR) && scl_rise
                                   && (q_reg.bit_cnt == BIT_LAST)
                                   && (new_byte != {SLAVE_ADDR, 1'b0})
                                   |=> (q_reg.state == ST_ACK_WAIT) && !q_reg.ack_ok)
    else $error("foreign address was accepted");
  // a word is exactly two bytes; more would overwrite the loaded value
  a_extra_refused: assert property ((q_reg.state == ST_DATA) && scl_rise
                                    && (q_reg.bit_cnt == BIT_LAST)
                                    && (q_reg.data_idx == DATA_BYTES)
                                    && (q_reg.sel != SEL_NONE)
                                    |=> !q_reg.ack_ok && !q_reg.pend)
    else $error("third data byte to a config word was accepted");

  c_load_a: cover property (commit_a);
  c_load_b: cover property (commit_b);
  c_refused: cover property ((q_reg.state == ST_IGNORE) && stop_cond);
  c_a_then_b: cover property (commit_a ##[1:1000] commit_b);

endmodule

/* core/apc_pkg.sv */
// constants shared by the audio path configuration register bank
// How it works
// - config a bits 15:14 set input amp gain; 01 means 9 dB attenuation.
// - config a bit 13 powers the input amplifier down when one.
// - config a bits 4:3 select output mux; 01 routes the input amplifier.
// - config a bits 2:1 drive speaker/aux stages; 01 is speaker high gain.
// - config a bit 0 powers the volume element down when one.
// - config a bit 10 powers the auxiliary input amplifier down when one.
// - config a bits 12:11 hold the auxiliary input amplifier gain.
// - config a bit 9 selects input source; zero picks the gain control amp.
// - config b bits 8:7 drive first mixer; 11 powers down, 01 mux only.
// - config b bits 6:5 drive second mixer; 11 powers down, 10 filter only.
// - config b bit 1 powers the low-pass filter down when one.
// - config b bit 0 powers the gain control amplifier down when one.
// - config b bits 3:2 pick filter band and sample rate; 01 is 6.4 kHz.
// - config b bit 4 selects filter input; zero picks the first mixer.
// - config b bits 10:9 select first mixer source; 00 is input amp.
// - config b bits 13:11 hold the volume element setting.
// - config b bits 15:14 select the volume element's feed.
// - new settings take effect on a rising edge of the serial clock.
// - config a bits 8:6 select analog output source; 000 is passthrough.
// - config a bit 5 powers the analog output amplifier down when one.
// - each value goes as two acked bytes, high byte first.
package apc_pkg;

  // serial framing
  localparam logic [6:0]  SLAVE_ADDR   = 7'h40;  // 80h write byte
  localparam logic [7:0]  CMD_LOAD_A   = 8'h88;  // plain default, load config a
  localparam logic [7:0]  CMD_LOAD_B   = 8'h98;  // plain default, load config b
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [1:0]  DATA_BYTES   = 2'h2;

  // values after reset
  localparam logic [15:0] CFG_A_RESET  = 16'h0000;
  localparam logic [15:0] CFG_B_RESET  = 16'h0000;

  // config a field positions
  localparam int A_VOL_PD_POS      = 0;
  localparam int A_SPK_AUX_LSB     = 1;
  localparam int A_OUT_MUX_LSB     = 3;
  localparam int A_LINE_OUT_PD_POS = 5;
  localparam int A_LINE_OUT_LSB    = 6;
  localparam int A_IN_SRC_POS      = 9;
  localparam int A_AUX_PD_POS      = 10;
  localparam int A_AUX_GAIN_LSB    = 11;
  localparam int A_LINE_IN_PD_POS  = 13;
  localparam int A_LINE_IN_GAIN_LSB = 14;

  // config b field positions
  localparam int B_AGC_PD_POS      = 0;
  localparam int B_FILT_PD_POS     = 1;
  localparam int B_FILT_RATE_LSB   = 2;
  localparam int B_FILT_MUX_POS    = 4;
  localparam int B_MIX2_LSB        = 5;
  localparam int B_MIX1_LSB        = 7;
  localparam int B_MIX1_SRC_LSB    = 9;
  localparam int B_ATTEN_LSB       = 11;
  localparam int B_LEVEL_MUX_LSB   = 14;

  // serial receiver states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_CMD      = 3'b010,
    ST_DATA     = 3'b011,
    ST_ACK_WAIT = 3'b100,
    ST_ACK      = 3'b101,
    ST_IGNORE   = 3'b110
  } apc_state_e;

  // register selected by the command byte
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_A    = 2'b01,
    SEL_B    = 2'b10
  } apc_sel_e;

endpackage

/* core/apc_sync.sv */
// two-stage synchroniser for the serial pins
`timescale 1ns/10ps
module apc_sync
  import apc_pkg::*;
#(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // idle bus level is high, so both stages reset high to avoid a fake start
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

/* verification/apc_host_model.sv */
// host side two-wire master model that loads the configuration words
`timescale 1ns/10ps
module apc_host_model (
  // clock
  input  wire logic       mclk,
  // serial data as seen on the wire
  input  wire logic       sda_wire,
  // serial clock and open-drain pull-down
  output logic            scl,
  output logic            sda_low,
  // ack seen per byte of the last frame, newest in bit 0
  output logic [4:0]      acks
);
  // both lines idle high, the clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    acks = 5'h00;
  end

  // clock high for five cycles, above the four the receiver needs
  task automatic high_phase();
    scl <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask

  // data only moves mid low phase so it never races the clock edges
  task automatic clk_bit(input logic low);
    scl <= 1'b0;
    repeat (2) @(posedge mclk);
    sda_low <= low;
    repeat (3) @(posedge mclk);
    high_phase();
  endtask

  // start, n bytes msb first each with an ack clock, then stop
  task automatic xfer(input logic [39:0] w, input int n);
    acks = 5'h00;
    sda_low <= 1'b1;
    repeat (5) @(posedge mclk);
    for (int k = 0; k < n; k++) begin
      for (int i = 39 - 8 * k; i > 31 - 8 * k; i--) begin
        clk_bit(~w[i]);
      end
      clk_bit(1'b0);
      acks = {acks[3:0], sda_wire === 1'b0};
    end
    clk_bit(1'b1);
    sda_low <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask
endmodule

/* verification/tb_top.sv */
// self-checking bench for the audio path configuration register bank
`timescale 1ns/10ps
module tb_top;
  import apc_pkg::*;

  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        scl;
  logic        sda_low;
  logic        sda_out;
  logic        sda_oe;
  logic [4:0]  acks;
  logic [15:0] cfg_a;
  logic [15:0] cfg_b;
  logic [15:0] exp_a;
  logic [15:0] exp_b;
  logic [15:0] ra;
  logic [15:0] rb;
  wire  [15:0] fld_a;
  wire  [15:0] fld_b;
  wire         sda_wire;
  int          errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  // pull-up on the data line, low when either party pulls
  assign sda_wire = (sda_low | sda_oe) ? 1'b0 : 1'b1;

  always #4 mclk = ~mclk;

  apc_host_model i_host (.mclk(mclk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low),
                         .acks(acks));

  // field ports gathered back into their word positions
  apc_config_regs i_dut (
    .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .path_config_a(cfg_a), .path_config_b(cfg_b),
    .volume_powerdown(fld_a[0]), .speaker_aux_ctl(fld_a[2:1]), .out_mux_sel(fld_a[4:3]),
    .line_out_powerdown(fld_a[5]), .line_out_mux_sel(fld_a[8:6]),
    .input_source_sel(fld_a[9]), .aux_in_powerdown(fld_a[10]), .aux_in_gain(fld_a[12:11]),
    .line_in_powerdown(fld_a[13]), .line_in_gain(fld_a[15:14]),
    .agc_amp_powerdown(fld_b[0]), .filter_powerdown(fld_b[1]), .filter_rate(fld_b[3:2]),
    .filter_mux_sel(fld_b[4]), .second_mixer_ctl(fld_b[6:5]), .first_mixer_ctl(fld_b[8:7]),
    .first_mixer_src(fld_b[10:9]), .attenuation_step(fld_b[13:11]),
    .level_mux_sel(fld_b[15:14]));

  // expected field outputs of a word, most significant field first
  function automatic logic [15:0] fields(input logic [15:0] w);
    fields = {w[15:14], w[13], w[12:11], w[10], w[9], w[8:6], w[5], w[4:3], w[2:1], w[0]};
  endfunction

  task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_ack(input logic [4:0] e);
    num_checks++;
    if (acks !== e) begin
      errors++;
      $display("ERROR acks expected %b seen %b", e, acks);
    end
  endtask

  task automatic check_regs(input string name);
    chk16("path_config_a", exp_a, cfg_a);
    chk16("path_config_b", exp_b, cfg_b);
    chk16("fields_a", fields(exp_a), fld_a);
    chk16("fields_b", fields(exp_b), fld_b);
    chk16("sda_out", 16'h0000, {15'h0000, sda_out});
    $display("test %s done", name);
  endtask

  // full load of one word; a command other than load a or load b leaves the model alone
  task automatic load(input logic [7:0] cmd, input logic [15:0] d);
    i_host.xfer({8'h80, cmd, d, 8'h00}, 4);
    chk_ack(5'h0f);
    if (cmd == CMD_LOAD_A) exp_a = d;
    if (cmd == CMD_LOAD_B) exp_b = d;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // a hang is cut short well beyond the roughly 9100 cycles the run needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      $display("ERROR timeout expected end seen hang");
      summarize();
    end
  end

  initial begin
    void'($urandom(49248));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    exp_a = 16'h0000;
    exp_b = 16'h0000;
    check_regs("reset");
    // pass-through setup, a strictly before b
    load(CMD_LOAD_A, 16'h440b);
    load(CMD_LOAD_B, 16'h01e3);
    check_regs("feed_through");
    // record path: only b changes so b alone is loaded
    load(CMD_LOAD_B, 16'h00c5);
    check_regs("call_record");
    // stop after the first data byte discards the load
    i_host.xfer({8'h80, CMD_LOAD_A, 16'hffff, 8'h00}, 3);
    chk_ack(5'h07);
    check_regs("abort");
    // foreign address is ignored entirely
    i_host.xfer({8'h82, CMD_LOAD_A, 16'hffff, 8'h00}, 4);
    chk_ack(5'h00);
    check_regs("wrong_addr");
    // fifth byte is refused, the word still lands
    i_host.xfer({8'h80, CMD_LOAD_B, 16'h5aa5, 8'h3c}, 5);
    chk_ack(5'h1e);
    exp_b = 16'h5aa5;
    check_regs("extra_byte");
    // a command that selects neither word loads nothing
    load(8'h77, 16'hffff);
    check_regs("other_cmd");
    // random words, sometimes b alone
    for (int n = 0; n < 10; n++) begin
      ra = 16'($urandom);
      rb = 16'($urandom);
      if (n % 3 != 2) load(CMD_LOAD_A, ra);
      load(CMD_LOAD_B, rb);
      check_regs("random");
    end
    summarize();
  end
endmodule
